/* File: hw/sira_device.sv */
// Purpose: Sensor register bank with sticky interrupt flags and bus slave
// Assumes: Link pins sampled by clk, host never stretches clock
// Notes: Measurement logic outside signals events and demands
//
// Functional notes
// - Status register 8Eh holds four flags
// - Bit 1 set on falling below low
// - Bit 0 set on rising above high
// - Flags stick until one written there
// - Interrupt pin low while any flag set
// - Host programs timing register with one
// - Host leaves register 90h alone
// - Standby without demands, emitter sink off
// - Address write, then read returns byte
// - Stop-start or repeated start both work
// - Pointer increments after each read byte
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module sira_device import sira_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = SIRA_SLAVE_ADDR
) (
	input wire logic clk,
	input wire logic rst_n,
	sira_link_if.dev link,
	input wire logic prox_ready_evt,
	input wire logic als_ready_evt,
	input wire logic below_low_limit_evt,
	input wire logic above_high_limit_evt,
	input wire logic prox_meas_req,
	input wire logic als_meas_req,
	output logic standby,
	output logic infrared_emitter_en,
	output logic [1:0] prox_freq_code,
	output logic [2:0] dead_time,
	output logic [2:0] delay_time,
	output logic [3:0] irq_flags
);
	typedef enum logic [5:0] {
		D_IDLE = 6'b000001,
		D_ADDR = 6'b000010,
		D_ACK = 6'b000100,
		D_RX = 6'b001000,
		D_TX = 6'b010000,
		D_RACK = 6'b100000
	} sira_dstate_type;

	sira_dstate_type state;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [3:0] cnt;
	logic byte_done;
	logic rw;
	logic ptr_phase;
	logic ack_ok;
	logic [7:0] ptr;
	logic sda_oe;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] mod_timing;
	logic [3:0] next_flags;
	logic [3:0] set_bits;
	logic [3:0] clr_bits;
	logic [7:0] rd_byte;
	logic int_n_q;

	// ==========================================================
	// Register read decode
	function automatic logic [7:0] reg_read(input logic [7:0] a,
		input logic [3:0] f, input logic [7:0] t);
		logic [7:0] v;
		v = 8'h00;
		if (a == SIRA_ADDR_IRQ_STATUS) begin
			v = {4'h0, f};
		end else if (a == SIRA_ADDR_MOD_TIMING) begin
			v = t;
		end
		return v;
	endfunction

	assign rd_byte = reg_read(ptr, irq_flags, mod_timing);

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], link.scl};
			sda_s <= {sda_s[0], link.sda};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
		end
	end

	// Edge and framing detection
	assign scl_rise = scl_s[1] & ~scl_d;
	assign scl_fall = ~scl_s[1] & scl_d;
	assign start_seen = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	assign stop_seen = scl_s[1] & scl_d & ~sda_d & sda_s[1];

	// ==========================================================
	// Bus slave sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= D_IDLE;
			shift <= 8'h00;
			tx <= 8'h00;
			cnt <= 4'h0;
			byte_done <= 1'b0;
			rw <= 1'b0;
			ptr_phase <= 1'b0;
			ack_ok <= 1'b0;
			ptr <= 8'h00;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (start_seen) begin
				// Start or repeated start both open a frame
				state <= D_ADDR;
				cnt <= 4'h0;
				byte_done <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				// Pointer survives the stop
				state <= D_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (state == D_ADDR || state == D_RX) begin
					shift <= {shift[6:0], sda_s[1]};
					cnt <= cnt + 4'h1;
					byte_done <= (cnt == 4'h7);
				end else if (state == D_TX) begin
					cnt <= cnt + 4'h1;
				end else if (state == D_RACK) begin
					ack_ok <= ~sda_s[1];
				end
			end else if (scl_fall) begin
				unique case (state)
					D_IDLE: begin
						sda_oe <= 1'b0;
					end
					D_ADDR: begin
						if (byte_done && shift[7:1] == SLAVE_ADDR) begin
							state <= D_ACK;
							sda_oe <= 1'b1;
							rw <= shift[0];
							// Write frame begins with pointer byte
							ptr_phase <= ~shift[0];
						end else if (byte_done) begin
							state <= D_IDLE;
						end
					end
					D_RX: begin
						if (byte_done) begin
							state <= D_ACK;
							sda_oe <= 1'b1;
							ptr_phase <= 1'b0;
							if (ptr_phase) begin
								ptr <= shift;
							end else begin
								wr_stb <= 1'b1;
								wr_addr <= ptr;
								wr_data <= shift;
								ptr <= ptr + 8'h01;
							end
						end
					end
					D_ACK: begin
						cnt <= 4'h0;
						byte_done <= 1'b0;
						if (rw) begin
							// Addressed byte goes out MSB first
							tx <= rd_byte;
							sda_oe <= ~rd_byte[7];
							state <= D_TX;
						end else begin
							sda_oe <= 1'b0;
							state <= D_RX;
						end
					end
					D_TX: begin
						if (cnt == 4'h8) begin
							sda_oe <= 1'b0;
							ptr <= ptr + 8'h01;
							state <= D_RACK;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
					D_RACK: begin
						if (ack_ok) begin
							// Next register without re-addressing
							tx <= rd_byte;
							sda_oe <= ~rd_byte[7];
							cnt <= 4'h0;
							state <= D_TX;
						end else begin
							state <= D_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Sticky flags, set beats clear
	always_comb begin
		set_bits = 4'h0;
		set_bits[SIRA_BIT_PROX_READY] = prox_ready_evt;
		set_bits[SIRA_BIT_ALS_READY] = als_ready_evt;
		set_bits[SIRA_BIT_BELOW_LOW] = below_low_limit_evt;
		set_bits[SIRA_BIT_ABOVE_HIGH] = above_high_limit_evt;
		clr_bits = 4'h0;
		if (wr_stb && wr_addr == SIRA_ADDR_IRQ_STATUS) begin
			clr_bits = wr_data[SIRA_IRQ_BITS-1:0];
		end
		next_flags = (irq_flags & ~clr_bits) | set_bits;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flags <= SIRA_IRQ_STATUS_RESET;
		end else begin
			irq_flags <= next_flags;
		end
	end

	// ==========================================================
	// Modulator timing register, reserved register never stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_timing <= SIRA_MOD_TIMING_RESET;
		end else if (wr_stb && wr_addr == SIRA_ADDR_MOD_TIMING) begin
			mod_timing <= wr_data;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_n_q <= 1'b1;
			standby <= 1'b1;
			infrared_emitter_en <= 1'b0;
			prox_freq_code <= SIRA_MOD_TIMING_RESET[SIRA_FREQ_MSB:SIRA_FREQ_LSB];
			dead_time <= SIRA_MOD_TIMING_RESET[SIRA_DEAD_MSB:SIRA_DEAD_LSB];
			delay_time <= SIRA_MOD_TIMING_RESET[SIRA_DELAY_MSB:SIRA_DELAY_LSB];
		end else begin
			int_n_q <= ~(|irq_flags);
			standby <= ~(prox_meas_req | als_meas_req);
			infrared_emitter_en <= prox_meas_req;
			prox_freq_code <= mod_timing[SIRA_FREQ_MSB:SIRA_FREQ_LSB];
			dead_time <= mod_timing[SIRA_DEAD_MSB:SIRA_DEAD_LSB];
			delay_time <= mod_timing[SIRA_DELAY_MSB:SIRA_DELAY_LSB];
		end
	end

	// Pin drive, data open-drain low only, interrupt driven both high and low
	assign link.int_n = int_n_q;
	assign link.dev_sda_oe = sda_oe;
	assign link.dev_sda_o = 1'b0;
endmodule // sira_device
`default_nettype wire

/* File: hw/sira_host.sv */
// Purpose: Host controller issuing register writes and reads to the sensor
// Assumes: Software on a plain strobe port, one op at a time
// Notes: Clock made by a quarter-bit divider
`timescale 1ns/100ps
`default_nettype none
module sira_host import sira_pkg::*; #(
	parameter int QUARTER_CYCLES = SIRA_QUARTER_CYCLES,
	parameter logic [6:0] SLAVE_ADDR = SIRA_SLAVE_ADDR
) (
	input wire logic clk,
	input wire logic rst_n,
	sira_link_if.host link,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [31:0] rdata,
	output logic irq
);
	// Divider counter is 16 bits wide
	if (QUARTER_CYCLES < 8 || QUARTER_CYCLES > 65536) begin : g_chk
		$error("QUARTER_CYCLES must lie between 8 and 65536");
	end

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BYTE = 4'b0100,
		H_STOP = 4'b1000
	} sira_hstate_type;

	sira_hstate_type state;
	logic [15:0] qcnt;
	logic tick;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [1:0] bnum;
	logic op_read;
	logic op_rs;
	logic pend;
	logic nak;
	logic [7:0] regaddr;
	logic [7:0] wdat;
	logic [7:0] rx_sh;
	logic [7:0] rbyte;
	logic scl;
	logic sda_oe;
	logic done_evt;
	logic nack_evt;
	logic [3:0] st;
	logic [3:0] mask;
	logic [3:0] next_st;
	logic [1:0] sda_s;
	logic [1:0] int_s;
	logic rxmode;
	logic [7:0] byte_val;
	logic [2:0] bidx;
	logic cmd_go;

	assign cmd_go = we && addr == SIRA_HOST_CMD && state == H_IDLE;
	assign rxmode = op_read && bnum == 2'h3;
	assign bidx = 3'h7 - bitn[2:0];
	assign byte_val = (bnum == 2'h0) ? {SLAVE_ADDR, 1'b0} :
		(bnum == 2'h1) ? regaddr :
		op_read ? {SLAVE_ADDR, 1'b1} : wdat;

	// ==========================================================
	// Input synchronisers and quarter-bit divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_s <= 2'h3;
			int_s <= 2'h3;
			qcnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			sda_s <= {sda_s[0], link.sda};
			int_s <= {int_s[0], link.int_n};
			tick <= (qcnt == 16'(QUARTER_CYCLES - 1));
			qcnt <= (qcnt == 16'(QUARTER_CYCLES - 1)) ? 16'h0000 :
				qcnt + 16'h0001;
		end
	end

	// ==========================================================
	// Frame sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= H_IDLE;
			q <= 2'h0;
			bitn <= 4'h0;
			bnum <= 2'h0;
			op_read <= 1'b0;
			op_rs <= 1'b0;
			pend <= 1'b0;
			nak <= 1'b0;
			regaddr <= 8'h00;
			wdat <= 8'h00;
			rx_sh <= 8'h00;
			rbyte <= 8'h00;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			done_evt <= 1'b0;
			nack_evt <= 1'b0;
		end else begin
			done_evt <= 1'b0;
			nack_evt <= 1'b0;
			if (cmd_go) begin
				// Continued read skips addressing
				regaddr <= wdata[7:0];
				wdat <= wdata[15:8];
				op_read <= wdata[SIRA_CMD_READ] | wdata[SIRA_CMD_CONT];
				op_rs <= wdata[SIRA_CMD_RSTART];
				bnum <= wdata[SIRA_CMD_CONT] ? 2'h2 : 2'h0;
				q <= 2'h0;
				state <= H_START;
			end else if (tick && state != H_IDLE) begin
				q <= q + 2'h1;
				unique case (state)
					H_START: begin
						if (q == 2'h0) sda_oe <= 1'b0;
						if (q == 2'h1) scl <= 1'b1;
						if (q == 2'h2) sda_oe <= 1'b1;
						if (q == 2'h3) begin
							scl <= 1'b0;
							bitn <= 4'h0;
							state <= H_BYTE;
						end
					end
					H_BYTE: begin
						if (q == 2'h0) sda_oe <= ~bitn[3] & ~rxmode & ~byte_val[bidx];
						if (q == 2'h1) scl <= 1'b1;
						if (q == 2'h2 && !bitn[3]) rx_sh <= {rx_sh[6:0], sda_s[1]};
						if (q == 2'h2 && bitn[3]) nak <= sda_s[1];
						if (q == 2'h3) begin
							scl <= 1'b0;
							bitn <= bitn + 4'h1;
							if (bitn[3]) begin
								bitn <= 4'h0;
								if (!rxmode && nak) begin
									nack_evt <= 1'b1;
									pend <= 1'b0;
									state <= H_STOP;
								end else if (rxmode) begin
									rbyte <= rx_sh;
									state <= H_STOP;
								end else if (bnum == 2'h2 && !op_read) begin
									state <= H_STOP;
								end else if (bnum == 2'h1 && op_read) begin
									// Restart or stop-start
									bnum <= 2'h2;
									pend <= ~op_rs;
									state <= op_rs ? H_START : H_STOP;
								end else begin
									bnum <= bnum + 2'h1;
								end
							end
						end
					end
					H_STOP: begin
						if (q == 2'h0) sda_oe <= 1'b1;
						if (q == 2'h1) scl <= 1'b1;
						if (q == 2'h2) sda_oe <= 1'b0;
						if (q == 2'h3) begin
							pend <= 1'b0;
							done_evt <= ~pend;
							state <= pend ? H_START : H_IDLE;
						end
					end
					default: state <= H_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Status, mask and interrupt; set beats clear
	always_comb begin
		next_st = st;
		if (we && addr == SIRA_HOST_STATUS) begin
			next_st = st & ~wdata[3:0];
		end
		next_st[SIRA_HST_DONE] = next_st[SIRA_HST_DONE] | done_evt;
		next_st[SIRA_HST_NACK] = next_st[SIRA_HST_NACK] | nack_evt;
		next_st[SIRA_HST_DEVIRQ] = next_st[SIRA_HST_DEVIRQ] | ~int_s[1];
		next_st[SIRA_HST_BUSY] = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= 4'h0;
			mask <= 4'h0;
			irq <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			st <= next_st;
			irq <= |(st & mask);
			if (we && addr == SIRA_HOST_MASK) mask <= wdata[3:0];
			rdata <= 32'h00000000;
			if (re && addr == SIRA_HOST_STATUS) begin
				rdata <= {28'h0000000, st[3:1], state != H_IDLE};
			end else if (re && addr == SIRA_HOST_MASK) begin
				rdata <= {28'h0000000, mask};
			end else if (re && addr == SIRA_HOST_RDATA) begin
				rdata <= {24'h000000, rbyte};
			end
		end
	end

	// Pin drive
	assign link.scl = scl;
	assign link.host_sda_oe = sda_oe;
	assign link.host_sda_o = 1'b0;
endmodule // sira_host
`default_nettype wire

/* File: hw/sira_link_if.sv */
// Purpose: Two-wire link between host controller and sensor
// Assumes: Open-drain data line with pull-up, host drives clock
// Notes: Wire level resolved here from the enables
`timescale 1ns/100ps
`default_nettype none
interface sira_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	logic int_n;
	// ==========================================================
	// Wired-and data line, pulled high when released
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output scl, output host_sda_o, output host_sda_oe,
		input sda, input int_n);
	modport dev (input scl, input sda, output dev_sda_o,
		output dev_sda_oe, output int_n);
endinterface
`default_nettype wire

/* File: hw/sira_pkg.sv */
// Purpose: Shared constants for the sensor register bank and its host
// Assumes: 50 MHz system clock on both ends
// Notes: Device map first, host controller map second
`default_nettype none
package sira_pkg;
	// ==========================================================
	// Device register map
	localparam logic [7:0] SIRA_ADDR_IRQ_STATUS = 8'h8e;
	localparam logic [7:0] SIRA_ADDR_MOD_TIMING = 8'h8f;
	localparam logic [7:0] SIRA_ADDR_AMBIENT_IR = 8'h90;
	localparam logic [7:0] SIRA_MOD_TIMING_RESET = 8'h01;
	localparam logic [3:0] SIRA_IRQ_STATUS_RESET = 4'h0;
	// Status bit positions
	localparam int SIRA_BIT_ABOVE_HIGH = 0;
	localparam int SIRA_BIT_BELOW_LOW = 1;
	localparam int SIRA_BIT_ALS_READY = 2;
	localparam int SIRA_BIT_PROX_READY = 3;
	localparam int SIRA_IRQ_BITS = 4;
	// Modulator timing field positions
	localparam int SIRA_DEAD_LSB = 0;
	localparam int SIRA_DEAD_MSB = 2;
	localparam int SIRA_FREQ_LSB = 3;
	localparam int SIRA_FREQ_MSB = 4;
	localparam int SIRA_DELAY_LSB = 5;
	localparam int SIRA_DELAY_MSB = 7;
	// Bus address of the sensor
	localparam logic [6:0] SIRA_SLAVE_ADDR = 7'h13;
	// ==========================================================
	// Host controller register map
	localparam logic [3:0] SIRA_HOST_CMD = 4'h0;
	localparam logic [3:0] SIRA_HOST_STATUS = 4'h4;
	localparam logic [3:0] SIRA_HOST_MASK = 4'h8;
	localparam logic [3:0] SIRA_HOST_RDATA = 4'hc;
	// Command fields
	localparam int SIRA_CMD_READ = 16;
	localparam int SIRA_CMD_RSTART = 17;
	localparam int SIRA_CMD_CONT = 18;
	// Host status bits
	localparam int SIRA_HST_BUSY = 0;
	localparam int SIRA_HST_DONE = 1;
	localparam int SIRA_HST_NACK = 2;
	localparam int SIRA_HST_DEVIRQ = 3;
	// ==========================================================
	// Timing
	localparam int SIRA_CLK_PERIOD_NS = 20;
	localparam int SIRA_SCL_PERIOD_NS = 10000;
	localparam int SIRA_QUARTER_CYCLES =
		SIRA_SCL_PERIOD_NS / (4 * SIRA_CLK_PERIOD_NS);
endpackage
`default_nettype wire

/* File: tb/sensor_irq_status_reg_access_tb.sv */
// Purpose: Self-checking bench for sensor register bank and its host
// Assumes: Quarter bit shortened to 8 clk
// Notes: Integer model of flags, timing register and pointer
`timescale 1ns/100ps
`default_nettype none
module sensor_irq_status_reg_access_tb import sira_pkg::*;;
	localparam int LIMIT = 90000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [3:0] evt = 4'h0;
	logic prox_req = 1'b0;
	logic als_req = 1'b0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic irq, standby, emit;
	logic [1:0] freq;
	logic [2:0] dead, delay;
	logic [3:0] flags;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int m_flags = 0;
	int m_timing = 1;
	int m_ptr = 0;
	// ==========================================================
	// Clock, the two ends and the wire checker
	always #10 clk = ~clk;
	sira_link_if u_sira_link_if();
	sira_host #(.QUARTER_CYCLES(8)) u_sira_host (.clk(clk), .rst_n(rst_n),
		.link(u_sira_link_if), .addr(addr), .wdata(wdata), .we(we),
		.re(re), .rdata(rdata), .irq(irq));
	sira_device u_sira_device (.clk(clk), .rst_n(rst_n),
		.link(u_sira_link_if), .prox_ready_evt(evt[3]),
		.als_ready_evt(evt[2]), .below_low_limit_evt(evt[1]),
		.above_high_limit_evt(evt[0]), .prox_meas_req(prox_req),
		.als_meas_req(als_req), .standby(standby),
		.infrared_emitter_en(emit), .prox_freq_code(freq),
		.dead_time(dead), .delay_time(delay), .irq_flags(flags));
	sira_link_props u_sira_link_props (.clk(clk), .rst_n(rst_n),
		.scl(u_sira_link_if.scl), .host_sda_oe(u_sira_link_if.host_sda_oe),
		.dev_sda_oe(u_sira_link_if.dev_sda_oe), .sda(u_sira_link_if.sda),
		.int_n(u_sira_link_if.int_n));
	// ==========================================================
	// Reporting and comparison
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_out(input string s, input logic [7:0] g,
		input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %0t: output %s got %h want %h", $time, s, g, e);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %0t: link byte got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_flags();
		chk_out("flags", 8'(flags), 8'(m_flags));
		chk_out("int_n", 8'(u_sira_link_if.int_n), 8'(m_flags == 0));
	endtask
	function automatic int mreg(input int p);
		if (p == int'(SIRA_ADDR_IRQ_STATUS))
			return m_flags;
		if (p == int'(SIRA_ADDR_MOD_TIMING))
			return m_timing;
		return 0;
	endfunction
	// ==========================================================
	// Software port and link operations
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic op(input logic [31:0] c);
		int i;
		wr(SIRA_HOST_CMD, c);
		for (i = 0; i < 2000; i++) begin
			rd(SIRA_HOST_STATUS, v);
			if (v[SIRA_HST_DONE] === 1'b1)
				break;
		end
		chk_out("done", 8'(v[SIRA_HST_NACK:SIRA_HST_DONE]), 8'h01);
		wr(SIRA_HOST_STATUS, 32'h6);
	endtask
	task automatic dev_wr(input logic [7:0] r, input logic [7:0] d);
		op({16'h0, d, r});
		if (r == SIRA_ADDR_IRQ_STATUS)
			m_flags = m_flags & ~int'(d[3:0]);
		if (r == SIRA_ADDR_MOD_TIMING)
			m_timing = d;
		m_ptr = (r + 1) & 255;
	endtask
	task automatic dev_rd(input logic [7:0] r, input logic rs, input logic cont);
		int p;
		op({13'h0, cont, rs, 1'b1, 8'h00, r});
		rd(SIRA_HOST_RDATA, v);
		p = cont ? m_ptr : int'(r);
		m_ptr = (p + 1) & 255;
		chk_byte(v[7:0], 8'(mreg(p)));
	endtask
	task automatic pulse(input logic [3:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 4'h0;
		m_flags = m_flags | e;
		repeat (3) @(posedge clk);
		chk_flags();
	endtask
	// ==========================================================
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			$display("Error %0t: timeout", $time);
			report_and_stop();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		int b;
		void'($urandom(32'h44c4));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_out("dead", 8'(dead), 8'h01);
		chk_out("freq", 8'(freq), 8'h00);
		chk_out("delay", 8'(delay), 8'h00);
		chk_out("standby", 8'(standby), 8'h01);
		chk_flags();
		dev_rd(SIRA_ADDR_MOD_TIMING, 1'b0, 1'b0);
		dev_rd(SIRA_ADDR_IRQ_STATUS, 1'b1, 1'b0);
		$display("test reset done");
		for (b = 0; b < 4; b++) begin
			pulse(4'(1 << b));
			dev_rd(SIRA_ADDR_IRQ_STATUS, b[0], 1'b0);
			dev_wr(SIRA_ADDR_IRQ_STATUS, {4'($urandom), 4'h0});
			chk_flags();
			dev_wr(SIRA_ADDR_IRQ_STATUS, 8'(1 << b));
			chk_flags();
		end
		pulse(4'h3);
		dev_wr(SIRA_ADDR_IRQ_STATUS, 8'hf1);
		chk_flags();
		dev_wr(SIRA_ADDR_IRQ_STATUS, 8'h02);
		chk_flags();
		$display("test flags done");
		v = $urandom;
		dev_wr(SIRA_ADDR_MOD_TIMING, v[7:0]);
		chk_out("freq", 8'(freq), 8'((m_timing >> SIRA_FREQ_LSB) & 3));
		chk_out("dead", 8'(dead), 8'(m_timing & 7));
		chk_out("delay", 8'(delay), 8'((m_timing >> SIRA_DELAY_LSB) & 7));
		pulse(4'h5);
		dev_rd(SIRA_ADDR_IRQ_STATUS, 1'b0, 1'b0);
		dev_rd(8'h00, 1'b1, 1'b1);
		// Pointer walk restarts below the reserved register
		dev_rd(8'h8d, 1'b1, 1'b0);
		dev_rd(8'h00, 1'b0, 1'b1);
		dev_rd(SIRA_ADDR_MOD_TIMING, 1'b1, 1'b0);
		dev_wr(SIRA_ADDR_MOD_TIMING, SIRA_MOD_TIMING_RESET);
		dev_wr(SIRA_ADDR_IRQ_STATUS, 8'h0f);
		chk_flags();
		$display("test timing and pointer done");
		@(posedge clk);
		prox_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk_out("standby", 8'(standby), 8'h00);
		chk_out("emit", 8'(emit), 8'h01);
		prox_req <= 1'b0;
		als_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk_out("standby", 8'(standby), 8'h00);
		chk_out("emit", 8'(emit), 8'h00);
		als_req <= 1'b0;
		repeat (3) @(posedge clk);
		chk_out("standby", 8'(standby), 8'h01);
		$display("test standby done");
		// Drop the device interrupt seen earlier, then arm the mask
		wr(SIRA_HOST_STATUS, 32'h8);
		wr(SIRA_HOST_MASK, 32'h8);
		repeat (2) @(posedge clk);
		chk_out("irq", 8'(irq), 8'h00);
		pulse(4'h8);
		repeat (3) @(posedge clk);
		chk_out("irq", 8'(irq), 8'h01);
		wr(SIRA_HOST_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk_out("irq", 8'(irq), 8'h00);
		wr(SIRA_HOST_MASK, 32'h8);
		dev_wr(SIRA_ADDR_IRQ_STATUS, 8'h08);
		wr(SIRA_HOST_STATUS, 32'h8);
		rd(SIRA_HOST_STATUS, v);
		chk_out("hstat", v[7:0], 8'h00);
		chk_out("irq", 8'(irq), 8'h00);
		rd(4'h2, v);
		chk_out("unmapped", v[7:0], 8'h00);
		$display("test host irq done");
		report_and_stop();
	end
endmodule // sensor_irq_status_reg_access_tb
`default_nettype wire

/* File: tb/sira_link_props.sv */
// Purpose: Wire checks on the link between host controller and sensor
// Assumes: Quarter bit of at least 8 clk, both ends design code
// Notes: Watches only the link signals
`timescale 1ns/100ps
`default_nettype none
module sira_link_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda,
	input wire logic int_n
);
	// ==========================================================
	// Cycles since the last clock line change
	logic scl_q;
	logic [7:0] idle_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			idle_cnt <= 8'h00;
		end else begin
			scl_q <= scl;
			if (scl != scl_q)
				idle_cnt <= 8'h00;
			else if (idle_cnt != 8'hff)
				idle_cnt <= idle_cnt + 8'h01;
		end
	end
	// ==========================================================
	// Frame conditions and properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	a_start_dev_quiet: assert property (
		s_start |-> !dev_sda_oe [*8]) else $error("device drives at start");
	a_stop_dev_free: assert property (
		s_stop |-> !dev_sda_oe [*8]) else $error("device drives at stop");
	a_dev_rise_low: assert property (
		$rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
		else $error("device grabs data while clock high");
	a_dev_fall_low: assert property (
		$fell(dev_sda_oe) |-> !scl) else $error("device releases on high");
	a_sda_high_edge: assert property (
		scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
		else $error("data moved by device while clock high");
	a_scl_high_width: assert property (
		$rose(scl) |-> scl [*8]) else $error("clock high too short");
	a_int_rise_bus: assert property (
		$rose(int_n) |-> idle_cnt < 8'h28)
		else $error("interrupt released without bus write");
	a_int_fall_hold: assert property (
		$fell(int_n) |-> !int_n [*8]) else $error("interrupt not held");
endmodule // sira_link_props
`default_nettype wire
